// ==== guard_asserts.sv ====
`timescale 1ns/100ps
module guard_asserts
  import regulator_guard_pkg::*;
#(
  parameter bit HIGH_RATE_VARIANT = 1'b0,
  parameter int OV_FILTER_CYCLES  = 8,
  parameter int HICCUP_CYCLES     = 20
) (
  input wire logic       CLK_I,
  input wire logic       NRST_I,
  input wire logic       EN_I,
  input wire logic       BIAS_OK_I,
  input wire logic       OC_TRIP_I,
  input wire logic       LS_ZERO_I,
  input wire logic       OV_ABOVE_I,
  input wire logic       OV_BELOW_HYST_I,
  input wire logic       OT_ABOVE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       HS_GATE_O,
  input wire logic       LS_GATE_O,
  input wire logic       RAMP_CLEAR_O,
  input wire logic       SW_TICK_O,
  input wire logic [1:0] OVERVOLT_TRIP_SELECT_O,
  input wire logic       OUTPUT_GOOD_FLAG_O,
  input wire logic       GOOD_PAD_O,
  input wire logic       GOOD_PAD_OE_N_O
);
  localparam int OVH = OV_FILTER_CYCLES + 4;
  localparam int HLO = HICCUP_CYCLES - 9;
  localparam int HHI = HICCUP_CYCLES - 4;
  localparam int TPM = (HIGH_RATE_VARIANT ? FSW_HIGH_CYC : FSW_LOW_CYC) - 1;
  logic [15:0] ov_run_q;
  logic        arm_q;
  logic        lat_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // ------------------------------------
  // over-voltage run length and latch
  // ------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ov_run_q <= 16'h0;
      arm_q    <= 1'b0;
      lat_q    <= 1'b0;
    end else begin
      ov_run_q <= OV_ABOVE_I ? ov_run_q + 16'h1 : 16'h0;
      if (!OV_ABOVE_I) arm_q <= 1'b0;
      else if (ov_run_q == 16'h0) arm_q <= !RAMP_CLEAR_O;
      if (!EN_I || !BIAS_OK_I) lat_q <= 1'b0;
      else if (ov_run_q == OVH && arm_q && LS_GATE_O && !HS_GATE_O) lat_q <= 1'b1;
    end
  end
  // ------------------------------------
  // properties
  // ------------------------------------
  property p_pad;
    GOOD_PAD_OE_N_O == OUTPUT_GOOD_FLAG_O && GOOD_PAD_O == 1'b0;
  endproperty
  a_pad: assert property (p_pad) else $error("good pad differs from flag");
  property p_en;
    (!EN_I)[*3] |=> !HS_GATE_O && !LS_GATE_O && RAMP_CLEAR_O && !OUTPUT_GOOD_FLAG_O;
  endproperty
  a_en: assert property (p_en) else $error("enable low left drivers on");
  property p_ot;
    OT_ABOVE_I[*3] |=> !HS_GATE_O && !LS_GATE_O && RAMP_CLEAR_O;
  endproperty
  a_ot: assert property (p_ot) else $error("thermal trip not taken");
  property p_oc;
    OC_TRIP_I[*3] ##0 (LS_GATE_O && !RAMP_CLEAR_O) |=> RAMP_CLEAR_O && !OUTPUT_GOOD_FLAG_O && !HS_GATE_O;
  endproperty
  a_oc: assert property (p_oc) else $error("over-current not taken");
  property p_drain;
    (RAMP_CLEAR_O && LS_GATE_O && !HS_GATE_O && !LS_ZERO_I && !OV_BELOW_HYST_I && EN_I && BIAS_OK_I
      && !OT_ABOVE_I)[*3] |=> LS_GATE_O;
  endproperty
  a_drain: assert property (p_drain) else $error("low side released early");
  property p_hic;
    $fell(LS_GATE_O) && RAMP_CLEAR_O && EN_I && BIAS_OK_I && !OT_ABOVE_I && !OV_BELOW_HYST_I
      |-> (RAMP_CLEAR_O && !HS_GATE_O && !LS_GATE_O)[*8] ##[HLO:HHI] !RAMP_CLEAR_O;
  endproperty
  a_hic: assert property (p_hic) else $error("hiccup blanking wrong");
  property p_ov;
    ov_run_q == OVH && arm_q && EN_I && !OV_BELOW_HYST_I |-> !HS_GATE_O && LS_GATE_O && !OUTPUT_GOOD_FLAG_O;
  endproperty
  a_ov: assert property (p_ov) else $error("over-voltage not taken");
  property p_lat;
    lat_q |-> !HS_GATE_O;
  endproperty
  a_lat: assert property (p_lat) else $error("high side left latch");
  property p_hys;
    (lat_q && OV_BELOW_HYST_I)[*3] |=> !LS_GATE_O;
  endproperty
  a_hys: assert property (p_hys) else $error("discharge not released");
  property p_sel;
    REG_WR_I && REG_ADDR_I == OV_TRIP_REG_ADDR |=> {6'h00, OVERVOLT_TRIP_SELECT_O} == ($past(REG_WDATA_I) & 8'h03);
  endproperty
  a_sel: assert property (p_sel) else $error("trip select not updated");
  property p_tick;
    SW_TICK_O |=> !SW_TICK_O ##TPM SW_TICK_O;
  endproperty
  a_tick: assert property (p_tick) else $error("switching period wrong");
  c_oc: cover property (OC_TRIP_I && LS_GATE_O);
  c_lat: cover property (lat_q);
  c_good: cover property ($rose(OUTPUT_GOOD_FLAG_O));
endmodule
bind regulator_fault_and_power_good_ctrl guard_asserts #(.HIGH_RATE_VARIANT(HIGH_RATE_VARIANT),
  .OV_FILTER_CYCLES(OV_FILTER_CYCLES), .HICCUP_CYCLES(HICCUP_CYCLES)) u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
  .EN_I(EN_I), .BIAS_OK_I(BIAS_OK_I), .OC_TRIP_I(OC_TRIP_I), .LS_ZERO_I(LS_ZERO_I), .OV_ABOVE_I(OV_ABOVE_I),
  .OV_BELOW_HYST_I(OV_BELOW_HYST_I), .OT_ABOVE_I(OT_ABOVE_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .HS_GATE_O(HS_GATE_O), .LS_GATE_O(LS_GATE_O),
  .RAMP_CLEAR_O(RAMP_CLEAR_O), .SW_TICK_O(SW_TICK_O), .OVERVOLT_TRIP_SELECT_O(OVERVOLT_TRIP_SELECT_O),
  .OUTPUT_GOOD_FLAG_O(OUTPUT_GOOD_FLAG_O), .GOOD_PAD_O(GOOD_PAD_O), .GOOD_PAD_OE_N_O(GOOD_PAD_OE_N_O));

// ==== regulator_fault_and_power_good_ctrl.sv ====
`timescale 1ns/100ps
module regulator_fault_and_power_good_ctrl
  import regulator_guard_pkg::*;
#(
  parameter bit HIGH_RATE_VARIANT = 1'b0,
  parameter int OV_FILTER_CYCLES  = OV_DELAY_CYC,
  parameter int HICCUP_CYCLES     = HICCUP_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       NRST_I,
  input  wire logic       EN_I,
  input  wire logic       BIAS_OK_I,
  input  wire logic       OC_TRIP_I,
  input  wire logic       LS_ZERO_I,
  input  wire logic       OV_ABOVE_I,
  input  wire logic       OV_BELOW_HYST_I,
  input  wire logic       OT_ABOVE_I,
  input  wire logic       OT_BELOW_HYST_I,
  input  wire logic       GOOD_ABOVE_I,
  input  wire logic       GOOD_BELOW_I,
  input  wire logic       RAMP_ABOVE_SENSE_I,
  input  wire logic       RAMP_NEAR_TARGET_I,
  input  wire logic       SENSE_TINY_I,
  input  wire logic       HS_REQ_I,
  input  wire logic       LS_REQ_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  output logic [7:0]      REG_RDATA_O,
  output logic            HS_GATE_O,
  output logic            LS_GATE_O,
  output logic            MIN_ON_O,
  output logic            RAMP_CLEAR_O,
  output logic            RAMP_RATE_O,
  output logic            SW_TICK_O,
  output logic [1:0]      OVERVOLT_TRIP_SELECT_O,
  output logic [1:0]      OVERTEMP_TRIP_SELECT_O,
  output logic [1:0]      GOOD_LEVEL_SELECT_O,
  output logic            OUTPUT_GOOD_FLAG_O,
  output logic            GOOD_PAD_O,
  output logic            GOOD_PAD_OE_N_O
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  generate
    if (OV_FILTER_CYCLES < 1 || OV_FILTER_CYCLES > 65535) begin : g_bad_ov
      $error("over-voltage filter length out of range");
    end
    if (HICCUP_CYCLES < 1 || HICCUP_CYCLES > 65535) begin : g_bad_hic
      $error("hiccup blanking length out of range");
    end
    if (FSW_LOW_CYC < 2 || FSW_LOW_CYC > 256) begin : g_bad_sw_low
      $error("low-rate switching period does not fit the divider");
    end
    if (FSW_HIGH_CYC < 2 || FSW_HIGH_CYC > 256) begin : g_bad_sw_high
      $error("high-rate switching period does not fit the divider");
    end
  endgenerate

  // ---------------------------------------------------------------
  // counter end points
  // ---------------------------------------------------------------
  localparam logic [15:0] OV_LIMIT  = 16'(OV_FILTER_CYCLES);
  localparam logic [15:0] HIC_LIMIT = 16'(HICCUP_CYCLES - 1);
  localparam logic [7:0]  SW_LIMIT  = HIGH_RATE_VARIANT ? 8'(FSW_HIGH_CYC - 1) : 8'(FSW_LOW_CYC - 1);

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input cfg_t cfg);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      POLICY_REG_ADDR: begin
        v[POLICY_BIT]    = cfg.policy;
        v[SOFT_STOP_BIT] = cfg.soft_stop;
        v[RAMP_RATE_BIT] = cfg.ramp_rate;
      end
      OV_TRIP_REG_ADDR:  v[1:0] = cfg.ov_sel;
      GOOD_LVL_REG_ADDR: v[1:0] = cfg.good_sel;
      OT_TRIP_REG_ADDR:  v[1:0] = cfg.ot_sel;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic is_active(input guard_state_t s);
    return (s == ST_START) || (s == ST_RUN) || (s == ST_OC_DRAIN) || (s == ST_HICCUP);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  guard_reg_t r_q;
  guard_reg_t r_d;
  sense_t     pins;
  sense_t     c;
  logic       en_ok;
  logic       ov_fault;
  logic       oc_fault;

  assign pins = '{enable:           EN_I,
                  bias_ok:          BIAS_OK_I,
                  oc_trip:          OC_TRIP_I,
                  ls_zero:          LS_ZERO_I,
                  ov_above:         OV_ABOVE_I,
                  ov_below_hyst:    OV_BELOW_HYST_I,
                  ot_above:         OT_ABOVE_I,
                  ot_below_hyst:    OT_BELOW_HYST_I,
                  good_above:       GOOD_ABOVE_I,
                  good_below:       GOOD_BELOW_I,
                  ramp_above_sense: RAMP_ABOVE_SENSE_I,
                  ramp_near_target: RAMP_NEAR_TARGET_I,
                  sense_tiny:       SENSE_TINY_I};

  assign c = r_q.s2;

  always_comb begin
    r_d = r_q;
    r_d.s1 = pins;
    r_d.s2 = r_q.s1;
    en_ok = c.enable & c.bias_ok;

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        POLICY_REG_ADDR: begin
          r_d.cfg.policy    = REG_WDATA_I[POLICY_BIT];
          r_d.cfg.soft_stop = REG_WDATA_I[SOFT_STOP_BIT];
          r_d.cfg.ramp_rate = REG_WDATA_I[RAMP_RATE_BIT];
        end
        OV_TRIP_REG_ADDR:  r_d.cfg.ov_sel = REG_WDATA_I[1:0];
        GOOD_LVL_REG_ADDR: r_d.cfg.good_sel = REG_WDATA_I[1:0];
        OT_TRIP_REG_ADDR:  r_d.cfg.ot_sel = REG_WDATA_I[1:0];
        default: ;
      endcase
    end
    r_d.rd_data = reg_read(REG_ADDR_I, r_q.cfg);

    // -------------------------------------------------------------
    // switching rate tick
    // -------------------------------------------------------------
    r_d.sw_tick = 1'b0;
    if (r_q.sw_cnt >= SW_LIMIT) begin
      r_d.sw_cnt  = 8'h00;
      r_d.sw_tick = 1'b1;
    end else begin
      r_d.sw_cnt = r_q.sw_cnt + 8'h01;
    end

    // -------------------------------------------------------------
    // fault detection
    // -------------------------------------------------------------
    ov_fault = 1'b0;
    if (c.ov_above && is_active(r_q.st)) begin
      if (r_q.ov_cnt == OV_LIMIT) begin
        ov_fault = 1'b1;
      end else begin
        r_d.ov_cnt = r_q.ov_cnt + 16'h0001;
      end
    end else begin
      r_d.ov_cnt = 16'h0000;
    end
    oc_fault = c.oc_trip & r_q.ls_gate;

    // -------------------------------------------------------------
    // protection sequencer
    // -------------------------------------------------------------
    r_d.hs_gate = 1'b0;
    r_d.ls_gate = 1'b0;
    case (r_q.st)
      ST_OFF: begin
        if (en_ok) begin
          r_d.st          = ST_START;
          r_d.first_pulse = 1'b0;
          r_d.start_done  = 1'b0;
          r_d.level_ok    = 1'b0;
        end
      end
      ST_START: begin
        if (c.ramp_above_sense) begin
          r_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        r_d.hs_gate = HS_REQ_I;
        r_d.ls_gate = LS_REQ_I & ~HS_REQ_I;
        if (HS_REQ_I) begin
          r_d.first_pulse = 1'b1;
        end
      end
      ST_OC_DRAIN: begin
        r_d.ls_gate = 1'b1;
        if (c.ls_zero) begin
          r_d.ls_gate = 1'b0;
          r_d.st      = ST_HICCUP;
          r_d.hic_cnt = 16'h0000;
        end
      end
      ST_HICCUP: begin
        if (r_q.hic_cnt >= HIC_LIMIT) begin
          r_d.st = ST_START;
        end else begin
          r_d.hic_cnt = r_q.hic_cnt + 16'h0001;
        end
      end
      ST_OT_SHUT: begin
        if (c.ot_below_hyst) begin
          r_d.st = ST_START;
        end
      end
      ST_OV_LATCH: begin
        if (c.ov_below_hyst) begin
          r_d.ls_released = 1'b1;
        end
        r_d.ls_gate = ~(r_q.ls_released | c.ov_below_hyst);
      end
      default: r_d.st = ST_OFF;
    endcase

    if (is_active(r_q.st)) begin
      if (ov_fault) begin
        r_d.st          = ST_OV_LATCH;
        r_d.ls_released = 1'b0;
        r_d.hs_gate     = 1'b0;
        r_d.ls_gate     = 1'b1;
      end else if (c.ot_above) begin
        r_d.st      = ST_OT_SHUT;
        r_d.hs_gate = 1'b0;
        r_d.ls_gate = 1'b0;
      end else if (oc_fault && (r_q.st == ST_RUN || r_q.st == ST_START)) begin
        r_d.st      = ST_OC_DRAIN;
        r_d.hs_gate = 1'b0;
        r_d.ls_gate = 1'b1;
      end
    end
    if (!en_ok) begin
      r_d.st      = ST_OFF;
      r_d.hs_gate = 1'b0;
      r_d.ls_gate = 1'b0;
    end

    r_d.ramp_clear = (r_d.st != ST_START) && (r_d.st != ST_RUN);
    r_d.min_on = (r_d.st == ST_RUN) && c.sense_tiny;

    // -------------------------------------------------------------
    // output good flag
    // -------------------------------------------------------------
    if (c.good_above) begin
      r_d.level_ok = 1'b1;
    end else if (c.good_below) begin
      r_d.level_ok = 1'b0;
    end
    if (!r_q.cfg.policy && !r_q.start_done && r_q.st == ST_RUN && r_q.first_pulse && c.ramp_near_target) begin
      r_d.start_done = 1'b1;
      r_d.level_ok   = 1'b1;
    end
    r_d.good = en_ok && (r_q.st == ST_RUN) && r_q.first_pulse && r_q.level_ok
               && (r_q.cfg.policy || r_q.start_done) && (r_d.st == ST_RUN);
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      r_q <= '{s1:          '0,
               s2:          '0,
               st:          ST_OFF,
               cfg:         '{policy:    POLICY_RESET,
                              soft_stop: SOFT_STOP_RESET,
                              ramp_rate: RAMP_RATE_RESET,
                              ov_sel:    OV_TRIP_RESET,
                              good_sel:  GOOD_LVL_RESET,
                              ot_sel:    OT_TRIP_RESET},
               ov_cnt:      16'h0000,
               hic_cnt:     16'h0000,
               sw_cnt:      8'h00,
               first_pulse: 1'b0,
               start_done:  1'b0,
               level_ok:    1'b0,
               ls_released: 1'b0,
               hs_gate:     1'b0,
               ls_gate:     1'b0,
               min_on:      1'b0,
               ramp_clear:  1'b1,
               good:        1'b0,
               sw_tick:     1'b0,
               rd_data:     8'h00};
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign REG_RDATA_O            = r_q.rd_data;
  assign HS_GATE_O              = r_q.hs_gate;
  assign LS_GATE_O              = r_q.ls_gate;
  assign MIN_ON_O               = r_q.min_on;
  assign RAMP_CLEAR_O           = r_q.ramp_clear;
  assign RAMP_RATE_O            = r_q.cfg.ramp_rate;
  assign SW_TICK_O              = r_q.sw_tick;
  assign OVERVOLT_TRIP_SELECT_O = r_q.cfg.ov_sel;
  assign OVERTEMP_TRIP_SELECT_O = r_q.cfg.ot_sel;
  assign GOOD_LEVEL_SELECT_O    = r_q.cfg.good_sel;
  assign OUTPUT_GOOD_FLAG_O     = r_q.good;
  // open drain: pull low unless good
  assign GOOD_PAD_O             = 1'b0;
  assign GOOD_PAD_OE_N_O        = r_q.good;

endmodule

// ==== regulator_guard_pkg.sv ====
package regulator_guard_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] POLICY_REG_ADDR  = 8'h14;
  localparam logic [7:0] OV_TRIP_REG_ADDR = 8'h17;
  localparam logic [7:0] GOOD_LVL_REG_ADDR = 8'h18;
  localparam logic [7:0] OT_TRIP_REG_ADDR = 8'h19;

  localparam int POLICY_BIT     = 0;
  localparam int SOFT_STOP_BIT  = 2;
  localparam int RAMP_RATE_BIT  = 3;

  localparam logic       POLICY_RESET   = 1'h1;
  localparam logic       SOFT_STOP_RESET = 1'h0;
  localparam logic       RAMP_RATE_RESET = 1'h0;
  localparam logic [1:0] OV_TRIP_RESET  = 2'h3;
  localparam logic [1:0] GOOD_LVL_RESET = 2'h2;
  localparam logic [1:0] OT_TRIP_RESET  = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ        = 100000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int FSW_LOW_KHZ    = 1100;
  localparam int FSW_HIGH_KHZ   = 1400;
  localparam int FSW_LOW_CYC    = (CLK_KHZ + FSW_LOW_KHZ / 2) / FSW_LOW_KHZ;
  localparam int FSW_HIGH_CYC   = (CLK_KHZ + FSW_HIGH_KHZ / 2) / FSW_HIGH_KHZ;
  localparam int OV_DELAY_NS    = 5000;
  localparam int OV_DELAY_CYC   = (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HICCUP_US      = 100;
  localparam int HICCUP_CYC     = (HICCUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic bias_ok;
    logic oc_trip;
    logic ls_zero;
    logic ov_above;
    logic ov_below_hyst;
    logic ot_above;
    logic ot_below_hyst;
    logic good_above;
    logic good_below;
    logic ramp_above_sense;
    logic ramp_near_target;
    logic sense_tiny;
  } sense_t;

  typedef enum logic [2:0] {
    ST_OFF      = 3'h0,
    ST_START    = 3'h1,
    ST_RUN      = 3'h3,
    ST_OC_DRAIN = 3'h2,
    ST_HICCUP   = 3'h6,
    ST_OT_SHUT  = 3'h7,
    ST_OV_LATCH = 3'h5
  } guard_state_t;

  typedef struct packed {
    logic       policy;
    logic       soft_stop;
    logic       ramp_rate;
    logic [1:0] ov_sel;
    logic [1:0] good_sel;
    logic [1:0] ot_sel;
  } cfg_t;

  typedef struct packed {
    sense_t       s1;
    sense_t       s2;
    guard_state_t st;
    cfg_t         cfg;
    logic [15:0]  ov_cnt;
    logic [15:0]  hic_cnt;
    logic [7:0]   sw_cnt;
    logic         first_pulse;
    logic         start_done;
    logic         level_ok;
    logic         ls_released;
    logic         hs_gate;
    logic         ls_gate;
    logic         min_on;
    logic         ramp_clear;
    logic         good;
    logic         sw_tick;
    logic [7:0]   rd_data;
  } guard_reg_t;

endpackage

// ==== stage_model.sv ====
`timescale 1ns/100ps
module stage_model (
  input  wire logic clk_i,
  input  wire logic ls_i,
  input  wire logic load_i,
  output logic      oc_o,
  output logic      zero_o,
  output logic      hs_req_o,
  output logic      ls_req_o
);
  logic [3:0] amps_q = 4'h0;
  logic [2:0] ph_q   = 3'h0;
  // ------------------------------------
  // low-side current and modulator
  // ------------------------------------
  always @(posedge clk_i) begin
    ph_q <= ph_q + 3'h1;
    if (ls_i && load_i) amps_q <= 4'h5;
    else if (ls_i && amps_q != 4'h0) amps_q <= amps_q - 4'h1;
  end
  assign oc_o     = ls_i && amps_q > 4'h4;
  assign zero_o   = amps_q == 4'h0;
  assign hs_req_o = ph_q < 3'h3;
  assign ls_req_o = !hs_req_o;
endmodule

// ==== tb_regulator_fault_and_power_good_ctrl.sv ====
`timescale 1ns/100ps
module tb_regulator_fault_and_power_good_ctrl;
  import regulator_guard_pkg::*;
  logic       clk  = 1'b0;
  logic       nrst = 1'b0;
  sense_t     sn   = '0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd   = 8'h00;
  logic       wr   = 1'b0;
  logic       load = 1'b0;
  logic [7:0] rdata, a, d;
  logic [1:0] ovs, ots, gls;
  logic       hs, ls, mon, rclr, rate, tick, good, pad, oen;
  wire logic  oc, lsz, hsr, lsr;
  int         err_count = 0;
  int         checked   = 0;
  int         i;
  always #5 clk = ~clk;
  regulator_fault_and_power_good_ctrl #(.OV_FILTER_CYCLES(8), .HICCUP_CYCLES(20)) DUT (
    .CLK_I(clk), .NRST_I(nrst), .EN_I(sn.enable), .BIAS_OK_I(sn.bias_ok), .OC_TRIP_I(oc), .LS_ZERO_I(lsz),
    .OV_ABOVE_I(sn.ov_above), .OV_BELOW_HYST_I(sn.ov_below_hyst), .OT_ABOVE_I(sn.ot_above),
    .OT_BELOW_HYST_I(sn.ot_below_hyst), .GOOD_ABOVE_I(sn.good_above), .GOOD_BELOW_I(sn.good_below),
    .RAMP_ABOVE_SENSE_I(sn.ramp_above_sense), .RAMP_NEAR_TARGET_I(sn.ramp_near_target),
    .SENSE_TINY_I(sn.sense_tiny), .HS_REQ_I(hsr), .LS_REQ_I(lsr), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RDATA_O(rdata), .HS_GATE_O(hs), .LS_GATE_O(ls), .MIN_ON_O(mon), .RAMP_CLEAR_O(rclr),
    .RAMP_RATE_O(rate), .SW_TICK_O(tick), .OVERVOLT_TRIP_SELECT_O(ovs), .OVERTEMP_TRIP_SELECT_O(ots),
    .GOOD_LEVEL_SELECT_O(gls), .OUTPUT_GOOD_FLAG_O(good), .GOOD_PAD_O(pad), .GOOD_PAD_OE_N_O(oen));
  stage_model u_stage (.clk_i(clk), .ls_i(ls), .load_i(load), .oc_o(oc), .zero_o(lsz), .hs_req_o(hsr),
    .ls_req_o(lsr));
  // ------------------------------------
  // tasks
  // ------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    addr <= ad;
    wd   <= dt;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    addr <= ad;
    step(1);
    @(negedge clk);
    chk(rdata, e);
  endtask
  function automatic logic [7:0] fold(input logic [7:0] ad, input logic [7:0] dt);
    if (ad == POLICY_REG_ADDR) return dt & 8'h0d;
    if (ad inside {OV_TRIP_REG_ADDR, GOOD_LVL_REG_ADDR, OT_TRIP_REG_ADDR}) return dt & 8'h03;
    return 8'h00;
  endfunction
  task automatic complete_run;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    complete_run;
  end
  // ------------------------------------
  // sequence
  // ------------------------------------
  initial begin
    i = $urandom(32'h870f825f);
    step(16);
    @(negedge clk);
    chk(oen, 1'b0);
    chk({hs, ls, rclr}, 3'b001);
    @(posedge clk);
    nrst       <= 1'b1;
    sn.bias_ok <= 1'b1;
    rd_reg(POLICY_REG_ADDR, 8'h01);
    rd_reg(OV_TRIP_REG_ADDR, 8'h03);
    rd_reg(GOOD_LVL_REG_ADDR, 8'h02);
    rd_reg(OT_TRIP_REG_ADDR, 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr_reg(OV_TRIP_REG_ADDR, 8'(c));
      wr_reg(GOOD_LVL_REG_ADDR, 8'(c));
      wr_reg(OT_TRIP_REG_ADDR, 8'(c));
      @(negedge clk);
      chk({2'b00, ovs, gls, ots}, {2'b00, {3{2'(c)}}});
    end
    repeat (8) begin
      a = 8'h14 + 8'($urandom_range(6));
      d = 8'($urandom);
      wr_reg(a, d);
      rd_reg(a, fold(a, d));
    end
    wr_reg(POLICY_REG_ADDR, 8'h09);
    @(negedge clk);
    chk(rate, 1'b1);
    wr_reg(POLICY_REG_ADDR, 8'h01);
    @(negedge clk);
    chk(rate, 1'b0);
    for (i = 0; i < 200 && tick !== 1'b1; i++) @(negedge clk);
    for (i = 1; i < 200; i++) begin
      @(negedge clk);
      if (tick === 1'b1) break;
    end
    chk(8'(i), 8'(FSW_LOW_CYC));
    @(posedge clk);
    sn.good_above <= 1'b1;
    sn.enable     <= 1'b1;
    step(20);
    @(negedge clk);
    chk({hs, ls}, 2'b00);
    chk(good, 1'b0);
    @(posedge clk);
    sn.ramp_above_sense <= 1'b1;
    for (i = 0; i < 40 && hs !== 1'b1; i++) @(negedge clk);
    chk(hs, 1'b1);
    for (i = 0; i < 20 && good !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    chk(good, 1'b1);
    chk({pad, oen}, 2'b01);
    @(posedge clk);
    sn.sense_tiny <= 1'b1;
    step(4);
    @(negedge clk);
    chk(mon, 1'b1);
    @(posedge clk);
    sn.sense_tiny <= 1'b0;
    sn.good_above <= 1'b0;
    step(6);
    @(negedge clk);
    chk(good, 1'b1);
    @(posedge clk);
    sn.good_below <= 1'b1;
    step(6);
    @(negedge clk);
    chk(good, 1'b0);
    @(posedge clk);
    sn.good_below <= 1'b0;
    sn.good_above <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      load <= 1'b1;
      for (i = 0; i < 40 && rclr !== 1'b1; i++) @(posedge clk);
      @(negedge clk);
      chk({rclr, good, hs, ls}, 4'b1001);
      @(posedge clk);
      load <= 1'b0;
      for (i = 0; i < 60 && rclr !== 1'b0; i++) @(posedge clk);
      chk(i >= 22 && i < 40, 1'b1);
    end
    step(10);
    @(posedge clk);
    sn.ot_above <= 1'b1;
    step(4);
    @(negedge clk);
    chk({hs, ls, rclr, good}, 4'b0010);
    @(posedge clk);
    sn.ot_above <= 1'b0;
    step(10);
    @(negedge clk);
    chk(rclr, 1'b1);
    @(posedge clk);
    sn.ot_below_hyst <= 1'b1;
    for (i = 0; i < 20 && rclr !== 1'b0; i++) @(posedge clk);
    @(negedge clk);
    chk(rclr, 1'b0);
    @(posedge clk);
    sn.ot_below_hyst <= 1'b0;
    sn.ov_above      <= 1'b1;
    step(6);
    @(negedge clk);
    chk(rclr, 1'b0);
    step(8);
    @(negedge clk);
    chk({hs, ls, good}, 3'b010);
    @(posedge clk);
    sn.ov_above      <= 1'b0;
    sn.ov_below_hyst <= 1'b1;
    step(4);
    @(negedge clk);
    chk(ls, 1'b0);
    step(30);
    @(negedge clk);
    chk(hs, 1'b0);
    @(posedge clk);
    sn.enable <= 1'b0;
    step(4);
    @(negedge clk);
    chk({hs, ls, rclr}, 3'b001);
    @(posedge clk);
    sn.ov_below_hyst <= 1'b0;
    sn.enable        <= 1'b1;
    for (i = 0; i < 40 && hs !== 1'b1; i++) @(negedge clk);
    chk(hs, 1'b1);
    wr_reg(POLICY_REG_ADDR, 8'h00);
    @(posedge clk);
    sn.enable <= 1'b0;
    step(4);
    @(posedge clk);
    sn.enable <= 1'b1;
    step(30);
    @(negedge clk);
    chk(good, 1'b0);
    @(posedge clk);
    sn.ramp_near_target <= 1'b1;
    for (i = 0; i < 20 && good !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    chk(good, 1'b1);
    @(posedge clk);
    sn.good_above <= 1'b0;
    sn.good_below <= 1'b1;
    step(6);
    @(negedge clk);
    chk(good, 1'b0);
    complete_run;
  end
endmodule
